//--- rtl/ldf_avalon_slave.sv
// module: avalon-mm slave handshake with one wait cycle
`timescale 1ns/1ps
module ldf_avalon_slave
    import ldf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // register side
    input  wire logic [31:0] rd_word,
    output ldf_bus_req_t     req
);

    logic        wait_q;
    logic [31:0] rdata_q;

    assign waitrequest = wait_q;
    assign readdata    = rdata_q;
    assign req         = '{wr_fire: write && !wait_q, addr: address, wdata: writedata};

    // ------------------------------------------------------------
    // wait generation: low for exactly one cycle per request
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if ((read || write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read data capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (read && wait_q) begin
            rdata_q <= rd_word;
        end
    end

    property p_wait_one;
        @(posedge clk) disable iff (!rst_n)
        !wait_q |=> wait_q;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low longer than one cycle");

endmodule : ldf_avalon_slave

//--- rtl/ldf_laser_drive_fault.sv
// module: emitter drive mode control, fault detection and switch output
// ------------------------------------------------------------
// What this block does
// - In normal operation the emitter current is driven as pulses.
// - A calibration mode drives the emitter continuously for testing.
// - After reset the forced-off bit is set and the laser stays off.
// - Writing 010b to bits 3..1 at 0x20 selects continuous calibration drive.
// - The switch output is low in normal operation and high on a fault.
// - A leakage path to ground on the cathode node raises a fault.
// - A fault cuts the drive current and drives the switch output high.
// - A periodic self-check pulls the cathode low with the laser switched off.
// - A self-check that does not see the node low reports a fault.
// - The switch output is active low: low enables the laser path.
// ------------------------------------------------------------
`timescale 1ns/1ps
module ldf_laser_drive_fault
    import ldf_pkg::*;
#(
    parameter int PULSE_PERIOD = PULSE_PERIOD_CYC,
    parameter int PULSE_ON     = PULSE_ON_CYC,
    parameter int TEST_PERIOD  = SELFTEST_PERIOD_CYC,
    parameter int TEST_SETTLE  = SETTLE_CYC
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // cathode sense
    input  wire logic        cathode_leak,
    // emitter outputs
    output logic             drive_current_pin,
    output logic             emitter_switch_off,
    output logic             cathode_pull
);

    localparam int PW = $clog2(PULSE_PERIOD + 1);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ldf_bus_req_t  req;
    logic [31:0]   rd_word;
    logic [7:0]    ctrl_q;
    logic          leak_q;
    logic          tfail_q;
    logic          fault_q;
    logic          drive_q;
    logic          switch_q;
    logic [PW-1:0] pcnt_q;
    logic          st_hold;
    logic          st_pull;
    logic          st_fail;
    logic          forced_off;
    logic          cal_mode;
    logic          run_ok;
    logic          leak_seen;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    ldf_avalon_slave u_bus (
        .clk         (clk),
        .rst_n       (rst_n),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .rd_word     (rd_word),
        .req         (req)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        return (a == base);
    endfunction : hit

    // ------------------------------------------------------------
    // emitter control register
    // ------------------------------------------------------------
    // forced off at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (req.wr_fire && hit(req.addr, ADDR_EMITTER_CONTROL)) begin
            ctrl_q <= req.wdata[7:0];
        end
    end

    assign forced_off = ctrl_q[CTRL_FORCED_OFF_BIT];
    assign cal_mode   = (ctrl_q[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_CALIBRATE);
    assign run_ok     = !forced_off && !fault_q && !st_hold;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(address, ADDR_EMITTER_CONTROL)) begin
            rd_word[7:0] = ctrl_q;
        end else if (hit(address, ADDR_FAULT_STATUS)) begin
            rd_word[STAT_FAULT_BIT]     = fault_q;
            rd_word[STAT_LEAK_BIT]      = leak_q;
            rd_word[STAT_TEST_FAIL_BIT] = tfail_q;
            rd_word[STAT_TEST_BUSY_BIT] = st_hold;
            rd_word[STAT_DRIVE_BIT]     = drive_q;
            rd_word[STAT_SWITCH_BIT]    = switch_q;
        end
    end

    // ------------------------------------------------------------
    // self-check sequencer
    // ------------------------------------------------------------
    ldf_self_test #(
        .PERIOD_CYC (TEST_PERIOD),
        .WAIT_CYC   (TEST_SETTLE)
    ) u_test (
        .clk          (clk),
        .rst_n        (rst_n),
        .run          (!fault_q),
        .cathode_leak (cathode_leak),
        .hold         (st_hold),
        .pull         (st_pull),
        .fail         (st_fail)
    );

    assign cathode_pull = st_pull;

    // ------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------
    // own pull is not a leak
    assign leak_seen = cathode_leak && !st_hold;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            leak_q <= 1'b0;
        end else if (leak_seen) begin
            leak_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tfail_q <= 1'b0;
        end else if (st_fail) begin
            tfail_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else if (leak_seen || st_fail) begin
            fault_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // drive current
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcnt_q <= '0;
        end else if (!run_ok || pcnt_q == PW'(PULSE_PERIOD - 1)) begin
            pcnt_q <= '0;
        end else begin
            pcnt_q <= pcnt_q + PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_q <= 1'b0;
        end else if (leak_seen || st_fail || !run_ok) begin
            drive_q <= 1'b0;
        end else if (cal_mode) begin
            drive_q <= 1'b1;
        end else begin
            drive_q <= (pcnt_q < PW'(PULSE_ON));
        end
    end

    assign drive_current_pin = drive_q;

    // ------------------------------------------------------------
    // switch output
    // ------------------------------------------------------------
    // high on fault, forced off or self-check hold, low otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            switch_q <= 1'b1;
        end else begin
            switch_q <= forced_off || fault_q || leak_seen || st_fail || st_hold;
        end
    end

    assign emitter_switch_off = switch_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [PW-1:0] on_run_q;
    logic          cal_prev_q;

    // drive left over from calibration
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cal_prev_q <= 1'b0;
        end else begin
            cal_prev_q <= cal_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            on_run_q <= '0;
        end else if (drive_q && !cal_mode && !cal_prev_q) begin
            on_run_q <= on_run_q + PW'(1);
        end else begin
            on_run_q <= '0;
        end
    end

    property p_pulsed;
        @(posedge clk) disable iff (!rst_n)
        on_run_q <= PW'(PULSE_ON);
    endproperty
    a_pulsed: assert property (p_pulsed) else $error("normal drive not pulsed");

    property p_cal_steady;
        @(posedge clk) disable iff (!rst_n)
        (cal_mode && run_ok && !cathode_leak) ##1 (cal_mode && run_ok) |-> drive_q;
    endproperty
    a_cal_steady: assert property (p_cal_steady) else $error("calibration drive not steady");

    property p_reset_off;
        @(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> forced_off && switch_q && !drive_q;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("laser not off after reset");

    property p_mode_write;
        @(posedge clk) disable iff (!rst_n)
        (req.wr_fire && hit(req.addr, ADDR_EMITTER_CONTROL) &&
         req.wdata[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_CALIBRATE) |=> cal_mode;
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("calibration mode not taken");

    property p_leak_fault;
        @(posedge clk) disable iff (!rst_n)
        (cathode_leak && !st_hold) |=> fault_q && leak_q;
    endproperty
    a_leak_fault: assert property (p_leak_fault) else $error("leak did not fault");

    // fault cuts drive and raises switch
    property p_fault_off;
        @(posedge clk) disable iff (!rst_n)
        $rose(fault_q) |-> !drive_q && switch_q;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault left laser on");

    // pull only with switch off and no current
    property p_pull_quiet;
        @(posedge clk) disable iff (!rst_n)
        st_pull |-> switch_q && !drive_q;
    endproperty
    a_pull_quiet: assert property (p_pull_quiet) else $error("pull with laser on");

    property p_test_fault;
        @(posedge clk) disable iff (!rst_n)
        st_fail |=> fault_q && tfail_q && switch_q;
    endproperty
    a_test_fault: assert property (p_test_fault) else $error("failed check not reported");

    // switch low only when running clean
    property p_switch_low;
        @(posedge clk) disable iff (!rst_n)
        !switch_q |-> !fault_q && !$past(forced_off);
    endproperty
    a_switch_low: assert property (p_switch_low) else $error("switch low while disabled");

    property p_fault_hold;
        @(posedge clk) disable iff (!rst_n)
        fault_q |=> fault_q && switch_q && !drive_q;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault released");

endmodule : ldf_laser_drive_fault

//--- rtl/ldf_pkg.sv
// package: register map, fields, timing and bus carrier types
package ldf_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 20;
    localparam int PULSE_PERIOD_NS    = 10000;
    localparam int PULSE_ON_NS        = 2000;
    localparam int SETTLE_NS          = 2000;
    localparam int SELFTEST_PERIOD_NS = 1000000;

    // least time, rounded up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int PULSE_PERIOD_CYC    = ns_to_cyc(PULSE_PERIOD_NS);
    localparam int PULSE_ON_CYC        = ns_to_cyc(PULSE_ON_NS);
    localparam int SETTLE_CYC          = ns_to_cyc(SETTLE_NS);
    localparam int SELFTEST_PERIOD_CYC = ns_to_cyc(SELFTEST_PERIOD_NS);

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_EMITTER_CONTROL = 8'h20;
    localparam logic [7:0] ADDR_FAULT_STATUS    = 8'h24;

    // emitter_control fields
    localparam int         CTRL_FORCED_OFF_BIT = 0;
    localparam int         CTRL_MODE_LSB       = 1;
    localparam int         CTRL_MODE_MSB       = 3;
    localparam logic [7:0] CTRL_RESET          = 8'h01;
    localparam logic [2:0] MODE_CALIBRATE      = 3'h2;

    // fault_status fields
    localparam int STAT_FAULT_BIT     = 0;
    localparam int STAT_LEAK_BIT      = 1;
    localparam int STAT_TEST_FAIL_BIT = 2;
    localparam int STAT_TEST_BUSY_BIT = 3;
    localparam int STAT_DRIVE_BIT     = 4;
    localparam int STAT_SWITCH_BIT    = 5;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr_fire;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ldf_bus_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OFF  = 4'b0010,
        ST_PULL = 4'b0100,
        ST_REL  = 4'b1000
    } ldf_test_state_t;

endpackage : ldf_pkg

//--- rtl/ldf_self_test.sv
// module: periodic self-check sequencer of the cathode fault detector
`timescale 1ns/1ps
module ldf_self_test
    import ldf_pkg::*;
#(
    parameter int PERIOD_CYC = SELFTEST_PERIOD_CYC,
    parameter int WAIT_CYC   = SETTLE_CYC
)(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control and sense
    input  wire logic run,
    input  wire logic cathode_leak,
    // results
    output logic      hold,
    output logic      pull,
    output logic      fail
);

    localparam int CW = $clog2(PERIOD_CYC + 1);

    ldf_test_state_t st_q;
    ldf_test_state_t st_d;
    logic [CW-1:0]   cnt_q;
    logic            pull_q;
    logic            fail_q;
    logic            done;

    assign hold = (st_q != ST_IDLE);
    assign pull = pull_q;
    assign fail = fail_q;
    assign done = (st_q == ST_IDLE) ? (cnt_q == CW'(PERIOD_CYC - 1))
                                    : (cnt_q == CW'(WAIT_CYC - 1));

    // ------------------------------------------------------------
    // sequence: quiet laser, pull node low, check, release
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (done && run) st_d = ST_OFF;
            ST_OFF:  if (done) st_d = ST_PULL;
            ST_PULL: if (done) st_d = ST_REL;
            ST_REL:  if (done) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (done || st_d != st_q) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pull_q <= 1'b0;
        end else begin
            pull_q <= (st_d == ST_PULL);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fail_q <= 1'b0;
        end else begin
            fail_q <= (st_q == ST_PULL) && done && !cathode_leak;
        end
    end

    property p_pull_in_window;
        @(posedge clk) disable iff (!rst_n)
        pull_q |-> (st_q == ST_PULL) && $past(hold);
    endproperty
    a_pull_in_window: assert property (p_pull_in_window) else $error("pull outside window");

endmodule : ldf_self_test

//--- verif/ldf_emitter_model.sv
// emitter side model: external p-channel switch and cathode node
`timescale 1ns/1ps
module ldf_emitter_model (
    // from the block
    input  wire logic emitter_switch_off,
    input  wire logic drive_current_pin,
    input  wire logic cathode_pull,
    // fault injection
    input  wire logic inject_leak,
    input  wire logic inject_short,
    // to the block and the bench
    output logic      cathode_leak,
    output logic      emitter_lit
);
    assign emitter_lit  = ~emitter_switch_off & drive_current_pin;
    assign cathode_leak = ~inject_short & (inject_leak | cathode_pull);
endmodule : ldf_emitter_model

//--- verif/testbench.sv
// testbench: bus tasks, read scoreboard and fault scenarios
`timescale 1ns/1ps
module testbench;
    import ldf_pkg::*;
    localparam int PP = 10;
    localparam int PO = 3;
    localparam int TP = 64;
    localparam int TS = 4;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
    } ldf_note_t;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        cathode_leak;
    logic        drive_current_pin;
    logic        emitter_switch_off;
    logic        cathode_pull;
    logic        emitter_lit;
    logic        leak = 1'b0;
    logic        short = 1'b0;
    logic [31:0] seed = 32'h7A40;
    ldf_note_t   notes[$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          hi;
    int          run_max;

    ldf_laser_drive_fault #(.PULSE_PERIOD(PP), .PULSE_ON(PO), .TEST_PERIOD(TP),
                            .TEST_SETTLE(TS)) ldf_laser_drive_fault_inst (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cathode_leak(cathode_leak), .drive_current_pin(drive_current_pin),
        .emitter_switch_off(emitter_switch_off), .cathode_pull(cathode_pull));

    ldf_emitter_model ldf_emitter_model_inst (
        .emitter_switch_off(emitter_switch_off), .drive_current_pin(drive_current_pin),
        .cathode_pull(cathode_pull), .inject_leak(leak), .inject_short(short),
        .cathode_leak(cathode_leak), .emitter_lit(emitter_lit));

    initial begin
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_word(what, {31'h0, exp}, {31'h0, got});
    endtask : check_bit

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic bus_go(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
        check_word("wait cycles", 32'h2, n);
    endtask : bus_go

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e & m, m});
        bus_go(1'b0, a, 32'h0);
    endtask : bus_rd

    task automatic watch_off(input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge clk);
            if (emitter_switch_off !== 1'b1 || drive_current_pin !== 1'b0)
                ok = 1'b0;
        end
        check_bit("laser held off", 1'b1, ok);
    endtask : watch_off

    task automatic watch_drive(input int n, output int h, output int rmax);
        int run;
        h = 0;
        run = 0;
        rmax = 0;
        repeat (n) begin
            @(posedge clk);
            run = (emitter_lit === 1'b1) ? run + 1 : 0;
            h = h + ((emitter_lit === 1'b1) ? 1 : 0);
            rmax = (run > rmax) ? run : rmax;
        end
    endtask : watch_drive

    // read results are scored against the oldest note
    always @(posedge clk) begin
        ldf_note_t nt;
        if (read === 1'b1 && waitrequest === 1'b0) begin
            nt = '1;
            if (notes.size() > 0)
                nt = notes.pop_front();
            check_word("readdata", nt.exp, readdata & nt.mask);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int n;
        do_reset();
        check_bit("switch in reset", 1'b1, emitter_switch_off);
        bus_rd(ADDR_EMITTER_CONTROL, {24'h0, CTRL_RESET}, 32'hFFFFFFFF);
        bus_rd(ADDR_FAULT_STATUS, 32'h20, 32'h37);
        watch_off(TP + 16);
        bus_go(1'b1, 8'h30, 32'hFFFFFFFF);
        bus_rd(8'h30, 32'h0, 32'hFFFFFFFF);
        seed = xs(seed);
        bus_go(1'b1, ADDR_EMITTER_CONTROL, {seed[31:8], seed[7:4], 4'h0});
        bus_rd(ADDR_EMITTER_CONTROL, {24'h0, seed[7:4], 4'h0}, 32'hFFFFFFFF);
        watch_drive(200, hi, run_max);
        check_bit("pulse width", 1'b1, hi > 0 && run_max == PO);
        n = 0;
        while (cathode_pull !== 1'b1 && n < 2 * TP) begin
            @(posedge clk);
            n++;
        end
        check_bit("pull seen", 1'b1, cathode_pull);
        check_bit("switch in pull", 1'b1, emitter_switch_off);
        check_bit("drive in pull", 1'b0, drive_current_pin);
        seed = xs(seed);
        bus_go(1'b1, ADDR_EMITTER_CONTROL, {seed[31:8], seed[7:4], 4'h4});
        bus_rd(ADDR_EMITTER_CONTROL, {24'h0, seed[7:4], 4'h4}, 32'hFFFFFFFF);
        repeat (2) @(posedge clk);
        watch_drive(200, hi, run_max);
        check_bit("continuous drive", 1'b1, run_max >= PP);
        bus_rd(ADDR_FAULT_STATUS, 32'h0, 32'h7);
        leak <= 1'b1;
        repeat (20) @(posedge clk);
        leak <= 1'b0;
        watch_off(TP * 2);
        bus_rd(ADDR_FAULT_STATUS, 32'h23, 32'h37);
        do_reset();
        bus_rd(ADDR_EMITTER_CONTROL, {24'h0, CTRL_RESET}, 32'hFFFFFFFF);
        bus_go(1'b1, ADDR_EMITTER_CONTROL, 32'h0);
        short <= 1'b1;
        repeat (TP * 2 + 3 * TS + 8) @(posedge clk);
        short <= 1'b0;
        watch_off(TP * 2);
        bus_rd(ADDR_FAULT_STATUS, 32'h25, 32'h37);
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule : testbench
